// ===== design/iac_core.sv
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////////
module iac_core
	import iac_pkg::*;
#(
	parameter int N_CH = 4
)
(
	input  wire logic          clk,
	input  wire logic          nrst,
	input  wire logic          sclk,
	input  wire logic          cs_n,
	input  wire logic          sdi,
	output logic               sdo,
	output logic               sdo_oe,
	output logic [N_CH-1:0]    compare_out_pin,
	output logic               compare_oe,
	output logic               alert_out,
	output logic               alert_oe,
	output logic               sample_req,
	output logic [1:0]         sample_chan,
	input  wire logic          sample_valid,
	input  wire logic [1:0]    sample_chan_in,
	input  wire logic [11:0]   sample_data,
	input  wire logic [7:0]    sample_check,
	output logic               sample_ready
);

	generate
		if (N_CH != NUM_CH || SLOT_CYC < 2 || SLOT_CYC > 255)
		begin : g_chk
			$error("iac_core serves four channels and a slot of 2..255 cycles");
		end
	endgenerate

	typedef struct packed {
		logic [1:0]              sclk_sy;
		logic [1:0]              cs_sy;
		logic [1:0]              sdi_sy;
		logic                    sclk_d;
		logic                    cs_d;
		logic [6:0]              bit_cnt;
		logic [31:0]             shin;
		logic [23:0]             shout;
		logic [3:0][15:0]        upper;
		logic [3:0][15:0]        lower;
		logic [15:0]             ctrl;
		logic [15:0]             irq_en;
		logic [15:0]             status;
		logic [3:0][11:0]        raw;
		logic [3:0][11:0]        avg;
		logic [3:0][3:0][11:0]   hist;
		logic [3:0]              cmp;
		logic                    pend;
		logic [1:0]              pch;
		logic [7:0]              slot_cnt;
		logic                    req;
		logic [1:0]              req_chan;
		logic                    sdo;
		logic                    sdo_oe;
		logic                    cmp_oe;
		logic                    alert_oe;
	} iac_state_t;

	iac_state_t s;
	iac_state_t next_s;

	logic        bo_valid;
	logic [21:0] bo_data;
	logic        bo_ready;
	logic [13:0] hsum;
	logic [11:0] cur_v;
	logic [11:0] cur_hi;
	logic [11:0] cur_lo;
	logic        cur_style;
	logic        cur_new;

	//////////////////////////////////////////////////////////////////////////
	// two-entry buffer on the converter data path
	iac_buf2 #(
		.W     (22),
		.DEPTH (2)
	) u_buf (
		.clk       (clk),
		.nrst      (nrst),
		.in_valid  (sample_valid),
		.in_data   ({sample_chan_in, sample_data, sample_check}),
		.in_ready  (sample_ready),
		.out_valid (bo_valid),
		.out_data  (bo_data),
		.out_ready (bo_ready)
	);

	assign bo_ready = ~s.pend;

	//////////////////////////////////////////////////////////////////////////
	// comparator operands for the channel in stage two
	assign hsum = 14'({2'b00, s.hist[s.pch][0]}) + 14'({2'b00, s.hist[s.pch][1]})
		+ 14'({2'b00, s.hist[s.pch][2]}) + 14'({2'b00, s.hist[s.pch][3]});
	assign cur_v     = s.ctrl[s.pch] ? hsum[13:2] : s.raw[s.pch];
	assign cur_hi    = s.upper[s.pch][11:0];
	assign cur_lo    = s.lower[s.pch][11:0];
	assign cur_style = s.upper[s.pch][MODE_BIT];

	function automatic logic cmp_eval(input logic sty, input logic [11:0] v,
		input logic [11:0] hi, input logic [11:0] lo, input logic prev);
		if (sty == IAC_WINDOW)
			return (v > hi) || (v < lo);
		else if (v > hi)
			return 1'b1;
		else if (v < lo)
			return 1'b0;
		else
			return prev;
	endfunction

	assign cur_new = cmp_eval(cur_style, cur_v, cur_hi, cur_lo, s.cmp[s.pch]);

	function automatic logic [15:0] reg_read(input logic [5:0] a);
		reg_read = 16'h0000;
		for (int c = 0; c < 4; c++)
		begin
			if (a == RAW_BASE + 6'(c))
				reg_read = {4'h0, s.raw[c]};
			if (a == AVG_BASE + 6'(c))
				reg_read = {4'h0, s.avg[c]};
			if (a == UPPER_OFS[c])
				reg_read = s.upper[c];
			if (a == LOWER_OFS[c])
				reg_read = s.lower[c];
		end
		if (a == STATUS_OFS)
			reg_read = s.status;
		if (a == IRQ_EN_OFS)
			reg_read = s.irq_en;
		if (a == CTRL_OFS)
			reg_read = s.ctrl;
	endfunction

	//////////////////////////////////////////////////////////////////////////
	// next state
	always_comb
	begin
		logic        in_frame;
		logic        sclk_rise;
		logic        sclk_fall;
		logic        cs_rise;
		logic        crc_on;
		logic [7:0]  hdr;
		logic [15:0] rd;
		logic [6:0]  exp_bits;
		logic [6:0]  idx;
		logic [1:0]  ch;
		next_s    = s;
		in_frame  = ~s.cs_sy[1];
		sclk_rise = s.sclk_sy[1] & ~s.sclk_d;
		sclk_fall = ~s.sclk_sy[1] & s.sclk_d;
		cs_rise   = s.cs_sy[1] & ~s.cs_d;
		crc_on    = s.ctrl[CRC_ON_BIT];
		exp_bits  = crc_on ? FRAME_CRC : FRAME_PLAIN;
		hdr       = {s.sdi_sy[1], s.shin[6:0]};
		rd        = reg_read(hdr[5:0]);
		idx       = s.bit_cnt - 7'(HDR_BITS);
		ch        = bo_data[21:20];

		next_s.sclk_sy = {s.sclk_sy[0], sclk};
		next_s.cs_sy   = {s.cs_sy[0], cs_n};
		next_s.sdi_sy  = {s.sdi_sy[0], sdi};
		next_s.sclk_d  = s.sclk_sy[1];
		next_s.cs_d    = s.cs_sy[1];

		// free-running conversion requests
		next_s.req = 1'b0;
		if (s.slot_cnt == 8'(SLOT_CYC - 1))
		begin
			next_s.slot_cnt = 8'h00;
			next_s.req      = 1'b1;
			next_s.req_chan = s.req_chan + 2'h1;
		end
		else
			next_s.slot_cnt = s.slot_cnt + 8'h01;

		// serial frame
		if (!in_frame)
		begin
			next_s.sdo_oe = 1'b0;
			next_s.sdo    = 1'b0;
			if (s.cs_sy[1] && !s.cs_d)
				next_s.bit_cnt = 7'h00;
		end
		if (in_frame && s.cs_d)
			next_s.bit_cnt = 7'h00;
		if (in_frame && sclk_rise)
		begin
			if (s.bit_cnt < FRAME_CRC)
				next_s.shin[s.bit_cnt[4:0]] = s.sdi_sy[1];
			if (s.bit_cnt != CNT_MAX)
				next_s.bit_cnt = s.bit_cnt + 7'h01;
			if (s.bit_cnt == 7'(HDR_BITS - 1) && !hdr[RW_BIT])
			begin
				next_s.shout = {iac_crc8({rd, hdr}), rd};
				if (hdr[5:0] == STATUS_OFS)
					next_s.status = 16'h0000;
			end
		end
		if (in_frame && sclk_fall && !s.shin[RW_BIT] && s.bit_cnt >= 7'(HDR_BITS))
		begin
			if (idx < (crc_on ? 7'h18 : 7'h10))
			begin
				next_s.sdo_oe = 1'b1;
				next_s.sdo    = s.shout[idx[4:0]];
			end
			else
				next_s.sdo_oe = 1'b0;
		end

		// frame end
		if (cs_rise)
		begin
			if (s.bit_cnt < exp_bits)
				next_s.status[STAT_FRAME] = 1'b1;
			else if (crc_on && s.shin[31:24] != iac_crc8(s.shin[23:0]))
				next_s.status[STAT_FCRC] = 1'b1;
			else if (s.shin[RW_BIT])
			begin
				for (int c = 0; c < 4; c++)
				begin
					if (s.shin[5:0] == UPPER_OFS[c])
						next_s.upper[c] = s.shin[23:8];
					if (s.shin[5:0] == LOWER_OFS[c])
						next_s.lower[c] = s.shin[23:8];
				end
				if (s.shin[5:0] == IRQ_EN_OFS)
					next_s.irq_en = s.shin[23:8];
				if (s.shin[5:0] == CTRL_OFS)
					next_s.ctrl = s.shin[23:8];
			end
		end

		// stage one: take a converter word
		next_s.pend = 1'b0;
		if (bo_valid && !s.pend)
		begin
			if (iac_crc8({10'h000, bo_data[21:8]}) == bo_data[7:0])
			begin
				next_s.raw[ch]  = bo_data[19:8];
				next_s.hist[ch] = {s.hist[ch][2:0], bo_data[19:8]};
				next_s.pend     = 1'b1;
				next_s.pch      = ch;
			end
			else
				next_s.status[STAT_LINK_CRC] = 1'b1;
		end

		// stage two: average and compare
		if (s.pend)
		begin
			next_s.avg[s.pch] = hsum[13:2];
			next_s.cmp[s.pch] = cur_new;
			if (cur_new != s.cmp[s.pch])
				next_s.status[s.pch] = 1'b1;
		end

		next_s.cmp_oe   = in_frame;
		next_s.alert_oe = |(s.status & s.irq_en);
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			s         <= '0;
			s.upper   <= {4{UPPER_RST}};
			s.lower   <= {4{LOWER_RST}};
			s.ctrl    <= CTRL_RST;
			s.irq_en  <= IRQ_EN_RST;
			s.sclk_sy <= 2'b00;
			s.cs_sy   <= 2'b11;
			s.cs_d    <= 1'b1;
		end
		else
			s <= next_s;
	end

	assign sdo             = s.sdo;
	assign sdo_oe          = s.sdo_oe;
	assign compare_out_pin = s.cmp;
	assign compare_oe      = s.cmp_oe;
	assign alert_out       = 1'b0;
	assign alert_oe        = s.alert_oe;
	assign sample_req      = s.req;
	assign sample_chan     = s.req_chan;

	//////////////////////////////////////////////////////////////////////////
	// checks
	a_sdo_float: assert property (@(posedge clk) disable iff (!nrst)
		s.cs_sy[1] |=> !sdo_oe)
		else $error("serial output driven while select high");

	a_cmp_float: assert property (@(posedge clk) disable iff (!nrst)
		s.cs_sy[1] |=> !compare_oe)
		else $error("comparator pins driven while select high");

	a_req_spacing: assert property (@(posedge clk) disable iff (!nrst)
		sample_req |=> !sample_req [*8])
		else $error("conversion requests too close");

	a_alert_follow: assert property (@(posedge clk) disable iff (!nrst)
		|(s.status & s.irq_en) |=> alert_oe && !alert_out)
		else $error("enabled cause did not pull alert");

	a_bad_check: assert property (@(posedge clk) disable iff (!nrst)
		bo_valid && !s.pend && iac_crc8({10'h000, bo_data[21:8]}) != bo_data[7:0]
		|=> s.status[STAT_LINK_CRC] && !s.pend)
		else $error("bad internal word not flagged or not discarded");

	a_window_high: assert property (@(posedge clk) disable iff (!nrst)
		s.pend && cur_style && (cur_v > cur_hi || cur_v < cur_lo) |=> s.cmp[$past(s.pch)])
		else $error("window style output not high outside limits");

	a_hyst_keep: assert property (@(posedge clk) disable iff (!nrst)
		s.pend && !cur_style && cur_v <= cur_hi && cur_v >= cur_lo |=> $stable(s.cmp))
		else $error("hysteresis output moved inside limits");

	a_change_flag: assert property (@(posedge clk) disable iff (!nrst)
		$changed(s.cmp) |-> (s.status[3:0] & (s.cmp ^ $past(s.cmp))) != 4'h0)
		else $error("comparator change not latched");

	a_reset_dflt: assert property (@(posedge clk)
		$rose(nrst) |-> !s.ctrl[CRC_ON_BIT] && !s.upper[0][MODE_BIT])
		else $error("frame check or style not default after reset");

endmodule

// ===== design/iac_pkg.sv
package iac_pkg;

	localparam int CLK_HZ      = 20_000_000;
	localparam int SAMPLE_SPS  = 20_000;
	localparam int NUM_CH      = 4;
	localparam int SLOT_CYC    = CLK_HZ / (SAMPLE_SPS * NUM_CH);
	localparam int RESP_RAW_US = 75;
	localparam int RESP_AVG_US = 300;
	localparam int RESP_RAW_CYC = (RESP_RAW_US * (CLK_HZ / 1_000_000));
	localparam int RESP_AVG_CYC = (RESP_AVG_US * (CLK_HZ / 1_000_000));
	localparam int SCLK_MAX_HZ = 10_000_000;
	localparam int ADC_BITS    = 12;
	localparam int AVG_DEPTH   = 4;

	localparam logic [5:0] RAW_BASE = 6'h01;
	localparam logic [5:0] AVG_BASE = 6'h05;
	localparam logic [3:0][5:0] UPPER_OFS = {6'h0C, 6'h0B, 6'h0A, 6'h09};
	localparam logic [3:0][5:0] LOWER_OFS = {6'h0F, 6'h0E, 6'h0D, 6'h10};
	localparam logic [5:0] STATUS_OFS = 6'h12;
	localparam logic [5:0] IRQ_EN_OFS = 6'h13;
	localparam logic [5:0] CTRL_OFS   = 6'h14;

	localparam int MODE_BIT      = 12;
	localparam int CRC_ON_BIT    = 7;
	localparam int STAT_LINK_CRC = 8;
	localparam int STAT_FRAME    = 9;
	localparam int STAT_FCRC     = 12;

	localparam logic [15:0] UPPER_RST  = 16'h0FFF;
	localparam logic [15:0] LOWER_RST  = 16'h0000;
	localparam logic [15:0] CTRL_RST   = 16'h0000;
	localparam logic [15:0] IRQ_EN_RST = 16'h0000;

	localparam int HDR_BITS  = 8;
	localparam int RW_BIT    = 6;
	localparam logic [6:0] FRAME_PLAIN = 7'h18;
	localparam logic [6:0] FRAME_CRC   = 7'h20;
	localparam logic [6:0] CNT_MAX     = 7'h7F;
	localparam logic [7:0] CRC_POLY    = 8'h07;
	localparam logic [7:0] CRC_INIT    = 8'h00;

	typedef enum logic [0:0] {IAC_HYST = 1'b0, IAC_WINDOW = 1'b1} iac_style_t;

	// crc over 24 bits, bit 0 first
	function automatic logic [7:0] iac_crc8(input logic [23:0] d);
		logic [7:0] c;
		logic       fb;
		c = CRC_INIT;
		for (int i = 0; i < 24; i++)
		begin
			fb = c[7] ^ d[i];
			c  = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
		end
		return c;
	endfunction

endpackage

// ===== design/iac_buf2.sv
`timescale 1ns/10ps
module iac_buf2
	import iac_pkg::*;
#(
	parameter int W     = 22,
	parameter int DEPTH = 2
)
(
	input  wire logic         clk,
	input  wire logic         nrst,
	input  wire logic         in_valid,
	input  wire logic [W-1:0] in_data,
	output logic              in_ready,
	output logic              out_valid,
	output logic [W-1:0]      out_data,
	input  wire logic         out_ready
);

	generate
		if (DEPTH != 2 || W < 1)
		begin : g_chk
			$error("iac_buf2 serves exactly two entries");
		end
	endgenerate

	typedef struct packed {
		logic         head_v;
		logic [W-1:0] head;
		logic         tail_v;
		logic [W-1:0] tail;
		logic         rdy;
	} iac_buf_t;

	iac_buf_t s;
	iac_buf_t next_s;

	always_comb
	begin
		logic pop;
		logic push;
		next_s = s;
		pop    = s.head_v & out_ready;
		push   = in_valid & ~s.tail_v;
		if (pop)
		begin
			next_s.head_v = s.tail_v;
			next_s.head   = s.tail;
			next_s.tail_v = 1'b0;
		end
		if (push)
		begin
			if (!next_s.head_v)
			begin
				next_s.head_v = 1'b1;
				next_s.head   = in_data;
			end
			else
			begin
				next_s.tail_v = 1'b1;
				next_s.tail   = in_data;
			end
		end
		// ready leaves from a flop, same timing as ~tail_v
		next_s.rdy = ~next_s.tail_v;
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			s     <= '0;
			s.rdy <= 1'b1;
		end
		else
			s <= next_s;
	end

	assign in_ready  = s.rdy;
	assign out_valid = s.head_v;
	assign out_data  = s.head;

	a_no_overrun: assert property (@(posedge clk) disable iff (!nrst)
		s.tail_v && !out_ready |=> s.tail_v && $stable(s.tail))
		else $error("buffer entry lost under stall");

endmodule

// ===== bench/iac_host.sv
`timescale 1ns/10ps
// serial host on four wires, sclk 2.5 MHz, no chain
module iac_host (
	output logic     sclk,
	output logic     cs_n,
	output logic     sdi,
	input wire logic sdo,
	input wire logic sdo_oe
);
	logic tog;
	wire  line = sdo_oe ? sdo : tog;

	initial
	begin
		sclk = 1'b0;
		cs_n = 1'b1;
		sdi  = 1'b0;
		tog  = 1'b0;
	end

	// address, rw, zero bit, data, then check byte when on
	task automatic frame(input logic [31:0] tx, input int n, output logic [31:0] rx);
		rx = 32'h0;
		cs_n = 1'b0;
		sdi = tx[0];
		#400;
		for (int i = 0; i < n; i++)
		begin
			#200 sclk = 1'b1;
			tog = ~tog;
			#190 rx[i] = line;
			#10 sclk = 1'b0;
			tog = ~tog;
			sdi = (i + 1 < n) ? tx[i+1] : ~sdi; // lsb first, change at falls
		end
		#200 cs_n = 1'b1;
		sdi = ~sdi;
		#400;
	endtask
endmodule

// ===== bench/iac_core_test.sv
`timescale 1ns/10ps
module iac_core_test
	import iac_pkg::*;
;
	logic        clk, nrst, sclk, cs_n, sdi, sdo, sdo_oe, compare_oe, alert_out, alert_oe;
	logic        sample_req, sample_valid, sample_ready, crc_on, stalled;
	logic [1:0]  sample_chan, sample_chan_in, e;
	logic [3:0]  pins;
	logic [7:0]  sample_check, qc;
	logic [11:0] sample_data, v;
	logic [15:0] rs, q, sum;
	int          errors, checked, cycles, k;
	logic [11:0] corner [6] = '{12'h800, 12'h801, 12'h600, 12'h400, 12'h3FF, 12'h600};

	iac_host host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe));

	iac_core dut (
		.clk(clk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo),
		.sdo_oe(sdo_oe), .compare_out_pin(pins), .compare_oe(compare_oe),
		.alert_out(alert_out), .alert_oe(alert_oe), .sample_req(sample_req),
		.sample_chan(sample_chan), .sample_valid(sample_valid),
		.sample_chan_in(sample_chan_in), .sample_data(sample_data),
		.sample_check(sample_check), .sample_ready(sample_ready)
	);

	////////////////////////////////////////////////////////////////
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			errors++;
			summarize();
		end
	end

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	// check byte, x8+x2+x+1, bit 0 first
	function automatic logic [7:0] crc(input logic [23:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 0; i < 24; i++)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
		return c;
	endfunction

	function automatic logic cmp(input logic win, input logic [11:0] x, input logic prev);
		if (win)
			return (x > 12'h800) || (x < 12'h400);
		return (x > 12'h800) ? 1'b1 : ((x < 12'h400) ? 1'b0 : prev);
	endfunction

	task automatic summarize();
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp)
		begin
			errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chkp(input logic [3:0] got, input logic [3:0] exp);
		checked++;
		if (got !== exp)
		begin
			errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic xfer(input logic [5:0] a, input logic w, input logic [15:0] d,
		input int n, input logic bad);
		logic [31:0] rx;
		host.frame({crc({d, 1'b0, w, a}) ^ {7'h00, bad}, d, 1'b0, w, a}, n, rx);
		q = rx[23:8];
		qc = rx[31:24];
	endtask

	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		xfer(a, 1'b1, d, crc_on ? 32 : 24, 1'b0);
	endtask

	task automatic rd(input logic [5:0] a, input logic [15:0] exp);
		xfer(a, 1'b0, 16'h0000, crc_on ? 32 : 24, 1'b0);
		chk16(q, exp);
		if (crc_on)
			chk16({8'h00, qc}, {8'h00, crc({exp, 2'b00, a})});
	endtask

	task automatic send(input logic [1:0] ch, input logic [11:0] d, input logic bad);
		@(negedge clk);
		sample_valid = 1'b1;
		sample_chan_in = ch;
		sample_data = d;
		sample_check = crc({10'h000, ch, d}) ^ {7'h00, bad};
		while (sample_ready !== 1'b1)
		begin
			stalled = 1'b1;
			@(negedge clk);
		end
	endtask

	////////////////////////////////////////////////////////////////
	initial
	begin
		nrst = 1'b0;
		sample_valid = 1'b0;
		sample_chan_in = 2'd0;
		sample_data = 12'h000;
		sample_check = 8'h00;
		errors = 0;
		checked = 0;
		cycles = 0;
		crc_on = 1'b0; // frame check off after reset
		stalled = 1'b0;
		e = 2'b00;
		rs = 16'h005D;
		repeat (6) @(negedge clk);
		nrst = 1'b1;
		repeat (3) @(negedge clk);
		chkp({sdo_oe, compare_oe, alert_oe, sample_ready}, 4'h1);
		for (k = 0; k < 400 && sample_req !== 1'b1; k++)
			@(negedge clk);
		chkp({3'b000, sample_req}, 4'h1);
		e = sample_chan;
		@(negedge clk);
		for (k = 1; k < 400 && sample_req !== 1'b1; k++)
			@(negedge clk);
		chkp({2'b00, sample_chan}, {2'b00, e + 2'd1});
		chk16(16'(k), 16'(SLOT_CYC));
		e = 2'b00;
		for (int i = 0; i < 4; i++)
		begin
			rd(UPPER_OFS[i], 16'h0FFF);
			rd(LOWER_OFS[i], 16'h0000);
			rs = lfsr(rs);
			wr(LOWER_OFS[i], {4'h0, rs[11:0]});
			rd(LOWER_OFS[i], {4'h0, rs[11:0]});
		end
		sum = 16'h0000;
		for (int i = 0; i < 4; i++)
		begin
			rs = lfsr(rs);
			sum = sum + {4'h0, rs[11:0]};
			send(2'd2, rs[11:0], 1'b0);
		end
		@(negedge clk) sample_valid = 1'b0;
		repeat (8) @(negedge clk);
		chkp({3'b000, stalled}, 4'h1);
		rd(AVG_BASE + 6'h02, {2'b00, sum[15:2]});
		wr(UPPER_OFS[0], 16'h0800);
		wr(LOWER_OFS[0], 16'h0400);
		wr(UPPER_OFS[1], 16'h1800);
		wr(LOWER_OFS[1], 16'h0400);
		wr(IRQ_EN_OFS, 16'h0001);
		for (int i = 0; i < 12; i++)
		begin
			rs = lfsr(rs);
			v = (i < 6) ? corner[i] : rs[11:0];
			send(2'd0, v, 1'b0);
			send(2'd1, v, 1'b0);
			@(negedge clk) sample_valid = 1'b0;
			e[0] = cmp(1'b0, v, e[0]);
			e[1] = cmp(1'b1, v, e[1]);
			repeat (8) @(negedge clk);
			chkp(pins & 4'h3, {2'b00, e});
		end
		rd(RAW_BASE, {4'h0, v});
		chkp({2'b00, alert_out, alert_oe}, 4'h1);
		xfer(STATUS_OFS, 1'b0, 16'h0000, 24, 1'b0);
		chk16(q & 16'h0001, 16'h0001);
		rd(STATUS_OFS, 16'h0000);
		chkp({3'b000, alert_oe}, 4'h0);
		send(2'd0, 12'h123, 1'b1);
		@(negedge clk) sample_valid = 1'b0;
		repeat (8) @(negedge clk);
		chkp({3'b000, alert_oe}, 4'h0);
		rd(RAW_BASE, {4'h0, v});
		rd(STATUS_OFS, 16'h0100);
		xfer(UPPER_OFS[3], 1'b1, 16'h0123, 16, 1'b0);
		rd(UPPER_OFS[3], 16'h0FFF);
		xfer(UPPER_OFS[3], 1'b1, 16'h0321, 28, 1'b0);
		rd(UPPER_OFS[3], 16'h0321);
		rd(STATUS_OFS, 16'h0200);
		chkp({2'b00, sdo_oe, compare_oe}, 4'h0);
		wr(CTRL_OFS, 16'h0080);
		crc_on = 1'b1;
		wr(UPPER_OFS[2], 16'h0456);
		rd(UPPER_OFS[2], 16'h0456);
		xfer(UPPER_OFS[2], 1'b1, 16'h0789, 32, 1'b1);
		rd(UPPER_OFS[2], 16'h0456);
		rd(STATUS_OFS, 16'h1000);
		// ch2 on averaged reading: 0x000 x4 then 0xFFF x2, limits 0x456/0x100
		wr(CTRL_OFS, 16'h0084);
		wr(LOWER_OFS[2], 16'h0100);
		for (int i = 0; i < 6; i++)
		begin
			send(2'd2, (i < 4) ? 12'h000 : 12'hFFF, 1'b0);
			@(negedge clk) sample_valid = 1'b0;
			repeat (8) @(negedge clk);
			if (i > 2)
				chkp(pins & 4'h4, (i == 5) ? 4'h4 : 4'h0);
		end
		summarize();
	end
endmodule
